// ### rtl/prc_ctrl.sv
`timescale 1ns/100ps
// ----------------------------------------
// Behaviour
// - Reference pin low crystal, high diff clock
// - Lock output follows PLL lock state
// - One divider per bank, same frequency
// - Bank D integer or fractional, others integer
// - Power-up: every function under pin control
// - Each function moves to registers independently
// - Only one source applied per function
// - Register values reset to defaults
// - Unselected register fields kept, no effect
// - Own select bit and pin pair each
// - Bank D register set selectable
// - Pin changes accepted, not glitch-free
// - Pin change may lose phase, fraction
// - Reinit restores phase and fraction
// - Divider write then reinit loads values
// - Pin pairs decoded from three levels
// - Open three-level pin reads middle
// - Input pins pick nine PLL presets
// ----------------------------------------
module prc_ctrl
  import prc_pkg::*;
(
  input wire logic core_clk_i, // Control clock
  input wire logic rstn_i, // Sync reset, active low
  input wire logic [ADDR_W-1:0] paddr_i, // APB address
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic ref_sel_i, // Reference select pin
  input wire logic pll_lock_i, // PLL lock detect
  input wire logic [3:0] input_freq_straps_i, // Input pins, 2 bits each
  input wire logic [3:0] bank_a_straps_i, // Bank A pins
  input wire logic [3:0] bank_b_straps_i, // Bank B pins
  input wire logic [3:0] bank_c_straps_i, // Bank C pins
  input wire logic [3:0] bank_d_straps_i, // Bank D pins
  output logic ref_clock_diff_sel_o, // 1 = differential ref
  output logic lock_o, // Lock status
  output logic [NUM_FN-1:0] source_sel_o, // 1 = register control
  output logic [NUM_FN*PRESET_W-1:0] preset_o, // Applied presets
  output logic [PLL_W-1:0] pll_cfg_o, // Applied PLL fields
  output logic [NUM_BANK*BANK_W-1:0] bank_cfg_o, // Banks A to C
  output logic [BANKD_W-1:0] bank_d_cfg_o, // Bank D fields
  output logic [FRAC_W-1:0] bank_d_fraction_o, // Bank D fraction
  output logic reinit_o, // Reload and realign pulse
  output logic phase_lost_o, // Alignment may be lost
  output logic frac_active_o // Fractional output running
);
  // ----------------------------------------
  // Registers and wires
  // ----------------------------------------
  logic [NUM_FN-1:0] sel_r; // Source selects
  logic [PLL_W-1:0] pll_r; // Prescaler, doubler, feedback
  logic [BANK_W-1:0] bank_r [NUM_BANK]; // Banks A to C
  logic [BANKD_W-1:0] bankd_r; // Bank D word
  logic [FRAC_W-1:0] frac_r; // Bank D fraction
  logic reinit_r; // Reinit pulse
  logic lost_r; // Sticky phase loss
  logic lock_r; // Lock output
  logic ref_r; // Reference select output
  logic frac_act_r; // Fraction running
  logic [31:0] prdata_r; // Read data
  logic pready_r; // Ready
  logic pslverr_r; // Error
  logic [31:0] rd_data; // Read mux
  logic rd_hit; // Mapped address
  logic setup; // APB setup phase
  logic wr_en; // Write commits
  logic any_chg; // Any pin change
  logic [3:0] pins [NUM_FN]; // Pin pairs by function
  logic [PRESET_W-1:0] dec [NUM_FN]; // Decoded presets
  logic [NUM_FN-1:0] chg; // Change pulses
  logic [PRESET_W-1:0] app [NUM_FN]; // Applied presets
  logic [BANK_W-1:0] bank_app [NUM_BANK]; // Applied bank fields
  logic [PLL_W-1:0] pll_app; // Applied PLL fields
  logic [BANKD_W+FRAC_W-1:0] d_app; // Applied bank D set
  logic [BANKD_W+FRAC_W-1:0] d_reg; // Bank D register set
  logic [NUM_BANK*BANK_W-1:0] bank_flat; // Flattened banks
  logic [NUM_FN*PRESET_W-1:0] preset_flat; // Flattened presets

  // Address compare, shared by read and write decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup = psel_i && !penable_i;
  // Writes land only at the edge that ends the access cycle
  assign wr_en = psel_i && penable_i && pready_r && pwrite_i;
  assign rd_hit = hit(paddr_i, OFS_CTRL) || hit(paddr_i, OFS_STAT)
    || hit(paddr_i, OFS_PLL) || hit(paddr_i, OFS_BANK_A)
    || hit(paddr_i, OFS_BANK_B) || hit(paddr_i, OFS_BANK_C)
    || hit(paddr_i, OFS_BANK_D) || hit(paddr_i, OFS_FRAC)
    || hit(paddr_i, OFS_STRAP);

  // Ready comes one cycle after setup: one access cycle, no waits
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      // Unmapped addresses answer with an error
      pslverr_r <= setup && !rd_hit;
      prdata_r <= setup && !pwrite_i ? rd_data : '0;
    end
  end

  // Read mux; reinit reads back zero since it is a pulse
  always_comb
  begin
    rd_data = '0;
    case (paddr_i)
      OFS_CTRL: rd_data[CTRL_SEL_LSB +: NUM_FN] = sel_r;
      OFS_STAT:
      begin
        rd_data[STAT_LOCK] = lock_r;
        rd_data[STAT_REF] = ref_r;
        rd_data[STAT_SEL_LSB +: NUM_FN] = sel_r;
        rd_data[STAT_LOST] = lost_r;
        rd_data[STAT_FRAC] = frac_act_r;
      end
      OFS_PLL: rd_data[PLL_W-1:0] = pll_r;
      OFS_BANK_A: rd_data[BANK_W-1:0] = bank_r[0];
      OFS_BANK_B: rd_data[BANK_W-1:0] = bank_r[1];
      OFS_BANK_C: rd_data[BANK_W-1:0] = bank_r[2];
      OFS_BANK_D: rd_data[BANKD_W-1:0] = bankd_r;
      OFS_FRAC: rd_data[FRAC_W-1:0] = frac_r;
      OFS_STRAP: rd_data[NUM_FN*PRESET_W-1:0] = preset_flat;
      default: rd_data = '0;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Control, PLL and bank D words; held while pins rule
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      sel_r <= SEL_RST;
      pll_r <= PLL_RST;
      bankd_r <= BANKD_RST;
      frac_r <= FRAC_RST;
    end
    else if (wr_en)
    begin
      if (hit(paddr_i, OFS_CTRL))
      begin
        sel_r <= pwdata_i[CTRL_SEL_LSB +: NUM_FN];
      end
      if (hit(paddr_i, OFS_PLL))
      begin
        pll_r <= pwdata_i[PLL_W-1:0];
      end
      if (hit(paddr_i, OFS_BANK_D))
      begin
        // Reserved bits are dropped so that they read back zero
        bankd_r <= pwdata_i[BANKD_W-1:0] & BANKD_MASK;
      end
      if (hit(paddr_i, OFS_FRAC))
      begin
        frac_r <= pwdata_i[FRAC_W-1:0];
      end
    end
  end

  // Banks A to C share one layout
  genvar b;
  generate
    for (b = 0; b < NUM_BANK; b++)
    begin : g_bank
      localparam logic [7:0] OFS = OFS_BANK_A + 8'(4 * b);
      always_ff @(posedge core_clk_i)
      begin
        if (!rstn_i)
        begin
          bank_r[b] <= BANK_RST;
        end
        else if (wr_en && hit(paddr_i, OFS))
        begin
          // Divider, powerdowns, style, swing
          // Reserved bits are dropped so that they read back zero
          bank_r[b] <= pwdata_i[BANK_W-1:0] & BANK_MASK;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Reinitialise and status
  // ----------------------------------------
  assign any_chg = |chg;

  // Reinit pulse, phase loss flag, pin status
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      reinit_r <= 1'b0;
      lost_r <= 1'b0;
      lock_r <= 1'b0;
      ref_r <= 1'b0;
      frac_act_r <= 1'b0;
    end
    else
    begin
      reinit_r <= wr_en && hit(paddr_i, OFS_CTRL) && pwdata_i[CTRL_REINIT_BIT];
      // Pin change flags phase loss
      // A pin change in the reinit cycle wins: alignment is still unsure
      if (any_chg)
      begin
        lost_r <= 1'b1;
      end
      else if (reinit_r)
      begin
        lost_r <= 1'b0;
      end
      lock_r <= pll_lock_i;
      ref_r <= ref_sel_i;
      // Fraction runs only when aligned
      // Held off until a reinit clears the loss, never mid-change
      frac_act_r <= d_app[BANKD_FRAC_BIT] && !lost_r && !any_chg;
    end
  end

  // ----------------------------------------
  // Pin decode and source select
  // ----------------------------------------
  assign pins[0] = input_freq_straps_i;
  assign pins[1] = bank_a_straps_i;
  assign pins[2] = bank_b_straps_i;
  assign pins[3] = bank_c_straps_i;
  assign pins[4] = bank_d_straps_i;

  genvar f;
  generate
    for (f = 0; f < NUM_FN; f++)
    begin : g_fn
      prc_strap_dec u_dec (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .pins_i(pins[f]),
        .preset_o(dec[f]),
        .chg_o(chg[f])
      );
      assign preset_flat[f*PRESET_W +: PRESET_W] = app[f];
    end
  endgenerate

  // Input side: prescaler, doubler, feedback divider
  prc_src_mux #(.W(PLL_W)) u_in_mux (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sel_i(sel_r[FN_IN]),
    .preset_i(dec[FN_IN]),
    .reg_i(pll_r),
    .reload_i(reinit_r),
    .preset_o(app[FN_IN]),
    .cfg_o(pll_app)
  );

  generate
    for (b = 0; b < NUM_BANK; b++)
    begin : g_bmux
      prc_src_mux #(.W(BANK_W)) u_mux (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .sel_i(sel_r[b+1]),
        .preset_i(dec[b+1]),
        .reg_i(bank_r[b]),
        .reload_i(reinit_r),
        .preset_o(app[b+1]),
        .cfg_o(bank_app[b])
      );
      assign bank_flat[b*BANK_W +: BANK_W] = bank_app[b];
    end
  endgenerate

  // Bank D carries integer word and fraction together
  assign d_reg = {frac_r, bankd_r};

  prc_src_mux #(.W(BANKD_W+FRAC_W)) u_d_mux (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sel_i(sel_r[FN_D]),
    .preset_i(dec[FN_D]),
    .reg_i(d_reg),
    .reload_i(reinit_r),
    .preset_o(app[FN_D]),
    .cfg_o(d_app)
  );

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign ref_clock_diff_sel_o = ref_r;
  assign lock_o = lock_r;
  assign source_sel_o = sel_r;
  assign preset_o = preset_flat;
  assign pll_cfg_o = pll_app;
  assign bank_cfg_o = bank_flat;
  assign bank_d_cfg_o = d_app[BANKD_W-1:0];
  assign bank_d_fraction_o = d_app[BANKD_W +: FRAC_W];
  assign reinit_o = reinit_r;
  assign phase_lost_o = lost_r;
  assign frac_active_o = frac_act_r;
endmodule // prc_ctrl

// ### rtl/prc_pkg.sv
// ----------------------------------------
// Control-source select shared definitions
// ----------------------------------------
package prc_pkg;
  // APB address width and register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_PLL = 8'h08;
  localparam logic [7:0] OFS_BANK_A = 8'h0C;
  localparam logic [7:0] OFS_BANK_B = 8'h10;
  localparam logic [7:0] OFS_BANK_C = 8'h14;
  localparam logic [7:0] OFS_BANK_D = 8'h18;
  localparam logic [7:0] OFS_FRAC = 8'h1C;
  localparam logic [7:0] OFS_STRAP = 8'h20;
  // Function indices, one select bit each
  localparam int NUM_FN = 5;
  localparam int FN_IN = 0;
  localparam int FN_D = 4;
  localparam int NUM_BANK = 3;
  // Field widths
  localparam int PLL_W = 16;
  localparam int BANK_W = 24;
  localparam int BANKD_W = 28;
  localparam int FRAC_W = 24;
  localparam int PRESET_W = 4;
  // Control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_REINIT_BIT = 8;
  // Status register fields
  localparam int STAT_LOCK = 0;
  localparam int STAT_REF = 1;
  localparam int STAT_SEL_LSB = 2;
  localparam int STAT_LOST = 8;
  localparam int STAT_FRAC = 9;
  // Bank D divider choice: 1 selects the fractional divider
  localparam int BANKD_FRAC_BIT = 17;
  // Reset values, all register control off
  localparam logic [NUM_FN-1:0] SEL_RST = 5'h00;
  localparam logic [PLL_W-1:0] PLL_RST = 16'h0000;
  localparam logic [BANK_W-1:0] BANK_RST = 24'h000000;
  localparam logic [BANKD_W-1:0] BANKD_RST = 28'h0000000;
  localparam logic [FRAC_W-1:0] FRAC_RST = 24'h000000;
  // Implemented bits of the bank words; the rest always read zero
  localparam logic [BANK_W-1:0] BANK_MASK = 24'hFFFF1F;
  localparam logic [BANKD_W-1:0] BANKD_MASK = 28'hD373F3F;
  // Three-level pin codes as seen by the comparators
  localparam logic [1:0] TRI_MID = 2'h1;
  localparam logic [1:0] TRI_OPEN = 2'h3;
  localparam logic [PRESET_W-1:0] TRI_LEVELS = 4'h3;

  // Open pin floats to middle through the bias network
  function automatic logic [1:0] prc_tri_lvl(input logic [1:0] code);
    return (code == TRI_OPEN) ? TRI_MID : code;
  endfunction

  // Pin pair to preset index 0..8, high pin most significant
  function automatic logic [PRESET_W-1:0] prc_preset(input logic [3:0] pins);
    return {2'h0, prc_tri_lvl(pins[3:2])} * TRI_LEVELS + {2'h0, prc_tri_lvl(pins[1:0])};
  endfunction
endpackage

// ### rtl/prc_strap_dec.sv
`timescale 1ns/100ps
// ----------------------------------------
// Strap pair decoder with change detect
// ----------------------------------------
module prc_strap_dec
  import prc_pkg::*;
(
  input wire logic core_clk_i, // Control clock
  input wire logic rstn_i, // Sync reset, active low
  input wire logic [3:0] pins_i, // Two three-level pin codes
  output logic [PRESET_W-1:0] preset_o, // Decoded preset index
  output logic chg_o // Pulse on a pin change
);
  logic [PRESET_W-1:0] preset_r; // Registered preset
  logic [PRESET_W-1:0] preset_nxt; // Fresh decode
  logic chg_r; // Change pulse
  logic valid_r; // First decode done

  assign preset_nxt = prc_preset(pins_i);

  // Decode register; the first sample after reset is not a change
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      preset_r <= '0;
      chg_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else
    begin
      preset_r <= preset_nxt;
      valid_r <= 1'b1;
      chg_r <= valid_r && (preset_nxt != preset_r);
    end
  end

  assign preset_o = preset_r;
  assign chg_o = chg_r;
endmodule // prc_strap_dec

// ### rtl/prc_src_mux.sv
`timescale 1ns/100ps
// ----------------------------------------
// Pin or register source select, one function
// ----------------------------------------
module prc_src_mux
  import prc_pkg::*;
#(
  parameter int W = BANK_W // Register field width
)
(
  input wire logic core_clk_i, // Control clock
  input wire logic rstn_i, // Sync reset, active low
  input wire logic sel_i, // 1 = register control
  input wire logic [PRESET_W-1:0] preset_i, // Pin preset
  input wire logic [W-1:0] reg_i, // Register fields
  input wire logic reload_i, // Reinitialise pulse
  output logic [PRESET_W-1:0] preset_o, // Applied preset
  output logic [W-1:0] cfg_o // Applied register fields
);
  logic sel_d_r; // Select, one cycle late
  logic [PRESET_W-1:0] preset_r; // Applied preset
  logic [W-1:0] cfg_r; // Applied fields
  logic load; // Take register fields now

  // Fresh select takes values at once
  assign load = sel_i && (!sel_d_r || reload_i);

  // Exactly one side is live; the other reads zero
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      sel_d_r <= 1'b0;
      preset_r <= '0;
      cfg_r <= '0;
    end
    else
    begin
      sel_d_r <= sel_i;
      preset_r <= sel_i ? '0 : preset_i;
      if (!sel_i)
      begin
        cfg_r <= '0;
      end
      else if (load)
      begin
        cfg_r <= reg_i;
      end
    end
  end

  assign preset_o = preset_r;
  assign cfg_o = cfg_r;
endmodule // prc_src_mux

// ### test/prc_ctrl_assertions.sv
`timescale 1ns/100ps
// ------
// Port checks for the source select block
// ------
module prc_ctrl_assertions
  import prc_pkg::*;
(
  input wire logic core_clk_i, // Control clock
  input wire logic rstn_i, // Sync reset, active low
  input wire logic [ADDR_W-1:0] paddr_i, // APB address
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [31:0] pwdata_i, // APB write data
  input wire logic pready_o, // APB ready
  input wire logic pslverr_o, // APB error
  input wire logic ref_sel_i, // Reference pin
  input wire logic pll_lock_i, // PLL lock
  input wire logic [3:0] bank_d_straps_i, // Bank D pins
  input wire logic ref_clock_diff_sel_o, // Reference choice
  input wire logic lock_o, // Lock status
  input wire logic [NUM_FN-1:0] source_sel_o, // Select bits
  input wire logic [NUM_FN*PRESET_W-1:0] preset_o, // Applied presets
  input wire logic reinit_o, // Reinit pulse
  input wire logic phase_lost_o // Alignment lost
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  // An open pin and a middle pin may look alike to the change detect
  wire logic d_open = (bank_d_straps_i[1:0] == 2'h3) || (bank_d_straps_i[3:2] == 2'h3);
  // Setup phase, then a committed control write
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_ctrl_wr;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_CTRL;
  endsequence
  // Select bits land as written
  property p_sel;
    logic [NUM_FN-1:0] v;
    (s_ctrl_wr, v = pwdata_i[NUM_FN-1:0]) |=> source_sel_o == v;
  endproperty
  a_ref_follow: assert property ($past(rstn_i) && $rose(ref_sel_i) |=> ref_clock_diff_sel_o)
    else $error("reference choice missed pin rise");
  a_lock_drop: assert property ($past(rstn_i) && $fell(pll_lock_i) |=> !lock_o)
    else $error("lock output stayed high");
  a_apb_ready: assert property (s_setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready_o |-> $past(psel_i) && !$past(penable_i))
    else $error("ready without setup");
  a_unmapped_err: assert property (s_setup ##0 (paddr_i > OFS_STRAP) |=> pready_o && pslverr_o)
    else $error("unmapped access not refused");
  a_sel_write: assert property (p_sel)
    else $error("select bits differ from write");
  a_reinit_cause: assert property (s_ctrl_wr ##0 pwdata_i[CTRL_REINIT_BIT] |=> reinit_o)
    else $error("reinit pulse missing");
  a_reinit_once: assert property (reinit_o |=> !reinit_o)
    else $error("reinit pulse too long");
  a_phase_lost: assert property (!d_open && !$past(d_open) && $changed(bank_d_straps_i)
    |-> ##[1:3] phase_lost_o)
    else $error("phase loss not flagged");
  a_preset_zero: assert property (source_sel_o[1] && $past(source_sel_o[1]) |-> preset_o[7:4] == 4'h0)
    else $error("pin preset applied with register control");
endmodule // prc_ctrl_assertions

bind prc_ctrl prc_ctrl_assertions u_prc_ctrl_assertions (.core_clk_i(core_clk_i),
  .rstn_i(rstn_i), .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ref_sel_i(ref_sel_i), .pll_lock_i(pll_lock_i), .bank_d_straps_i(bank_d_straps_i),
  .ref_clock_diff_sel_o(ref_clock_diff_sel_o), .lock_o(lock_o),
  .source_sel_o(source_sel_o), .preset_o(preset_o), .reinit_o(reinit_o),
  .phase_lost_o(phase_lost_o));

// ### test/prc_host_model.sv
`timescale 1ns/100ps
// ------
// Host controller on the register bus
// ------
module prc_host_model
(
  input wire logic core_clk_i, // Control clock
  input wire logic pready_i, // Ready from device
  output logic [7:0] paddr_o = 8'h00, // Address
  output logic psel_o = 1'b0, // Select
  output logic penable_o = 1'b0, // Enable
  output logic pwrite_o = 1'b0, // Direction
  output logic [31:0] pwdata_o = 32'h0 // Write data
);
  // One transfer, request held until ready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    // No wait count assumed, the bench watchdog ends a hang
    do
      @(posedge core_clk_i);
    while (pready_i !== 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released lines must not keep the old value
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule // prc_host_model

// ### test/pin_register_control_select_tb.sv
`timescale 1ns/100ps
// ------
// Self-checking bench for the source select block
// ------
module pin_register_control_select_tb;
  import prc_pkg::*;
  logic core_clk_i = 1'b0; // 40 MHz clock
  logic rstn_i = 1'b0; // Reset, active low
  logic ref_sel = 1'b0; // Reference pin
  logic pll_lock = 1'b0; // PLL lock
  logic [NUM_FN-1:0][3:0] straps = '0; // Pin pairs per function
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr, ref_diff, lock, reinit, lost, frac;
  logic [31:0] pwdata, prdata;
  logic [NUM_FN-1:0] src_sel;
  logic [NUM_FN*PRESET_W-1:0] preset;
  logic [PLL_W-1:0] pll_cfg;
  logic [NUM_BANK*BANK_W-1:0] bank_cfg;
  logic [BANKD_W-1:0] d_cfg;
  logic [FRAC_W-1:0] d_frac;
  logic [32:0] notes [$]; // Expected {error, data} of reads
  int miscompares = 0;
  int checks = 0;
  always #12.5 core_clk_i = ~core_clk_i;

  prc_ctrl u_prc_ctrl (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ref_sel_i(ref_sel),
    .pll_lock_i(pll_lock), .input_freq_straps_i(straps[0]), .bank_a_straps_i(straps[1]),
    .bank_b_straps_i(straps[2]), .bank_c_straps_i(straps[3]), .bank_d_straps_i(straps[4]),
    .ref_clock_diff_sel_o(ref_diff), .lock_o(lock), .source_sel_o(src_sel),
    .preset_o(preset), .pll_cfg_o(pll_cfg), .bank_cfg_o(bank_cfg), .bank_d_cfg_o(d_cfg),
    .bank_d_fraction_o(d_frac), .reinit_o(reinit), .phase_lost_o(lost),
    .frac_active_o(frac));
  prc_host_model u_prc_host_model (.core_clk_i(core_clk_i), .pready_i(pready),
    .paddr_o(paddr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .pwdata_o(pwdata));

  // Compare and count
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    notes.push_back(exp);
    u_prc_host_model.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_prc_host_model.xfer(1'b1, a, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // Pin level, open counts as middle
  function automatic logic [3:0] lv(input logic [1:0] c);
    return (c == 2'h3) ? 4'h1 : {2'h0, c};
  endfunction
  function automatic logic [19:0] presets(input logic [NUM_FN-1:0][3:0] s);
    logic [19:0] r;
    for (int f = 0; f < NUM_FN; f++)
      r[4*f +: 4] = 4'h3 * lv(s[f][3:2]) + lv(s[f][1:0]);
    return r;
  endfunction
  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Completed reads meet the oldest note
  always @(posedge core_clk_i)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, notes.size() ? notes.pop_front() : 33'h1FFFFFFFF);
  end

  // Watchdog, the run needs well under a thousand cycles
  initial
  begin
    tick(5000);
    miscompares++;
    report_and_stop();
  end

  // ------
  // Main sequence
  // ------
  initial
  begin
    logic [31:0] v;
    void'($urandom(32'h343d));
    tick(20);
    rstn_i <= 1'b1;
    tick(2);
    for (int i = 0; i < 8; i++)
    begin
      if (i != 1)
        rd(8'(4 * i), 33'h0);
    end
    for (int i = 0; i < 4; i++)
    begin
      ref_sel <= i[0];
      pll_lock <= i[1];
      tick(3);
      chk(33'({ref_diff, lock}), 33'({i[0], i[1]}));
      rd(OFS_STAT, 33'({i[0], i[1]}));
    end
    // Random pin codes, open included
    repeat (6)
    begin
      for (int f = 0; f < NUM_FN; f++)
        straps[f] <= 4'($urandom);
      tick(4);
      rd(OFS_STRAP, 33'(presets(straps)));
      chk(33'(preset), 33'(presets(straps)));
    end
    // Pins away from zero so that a leaked pin preset shows
    straps <= {NUM_FN{4'h6}};
    v = $urandom;
    wr(OFS_BANK_A, v);
    rd(OFS_BANK_A, 33'(v[23:0] & 24'hFFFF1F));
    chk(33'(bank_cfg[23:0]), 33'h0);
    wr(OFS_CTRL, 32'h2);
    tick(4);
    chk(33'(bank_cfg[23:0]), 33'(v[23:0] & 24'hFFFF1F));
    chk(33'(preset), 33'(presets(straps) & 20'hFFF0F));
    chk(33'(pll_cfg), 33'h0);
    // Outputs powered down before the divider changes
    wr(OFS_BANK_A, 32'h10);
    wr(OFS_CTRL, 32'h102);
    tick(4);
    chk(33'(bank_cfg[23:0]), 33'h10);
    wr(OFS_BANK_A, ~v);
    tick(4);
    chk(33'(bank_cfg[23:0]), 33'h10);
    wr(OFS_CTRL, 32'h102);
    tick(4);
    chk(33'(bank_cfg[23:0]), 33'(~v[23:0] & 24'hFFFF1F));
    rd(OFS_CTRL, 33'h2);
    // Bank D on the fractional divider
    wr(OFS_BANK_D, 32'h20005);
    wr(OFS_FRAC, v);
    wr(OFS_PLL, v);
    wr(OFS_CTRL, 32'h113);
    tick(4);
    chk(33'({lost, frac, d_cfg}), 33'({2'b01, 28'h0020005}));
    chk(33'(d_frac), 33'(v[23:0]));
    chk(33'(pll_cfg), 33'(v[15:0]));
    straps[FN_D] <= 4'h9;
    tick(4);
    chk(33'({lost, frac}), 33'h2);
    wr(OFS_CTRL, 32'h110);
    tick(5);
    chk(33'({lost, frac}), 33'h1);
    chk(33'(bank_cfg[23:0]), 33'h0);
    rd(OFS_BANK_A, 33'(~v[23:0] & 24'hFFFF1F));
    wr(OFS_STAT, 32'hFFFFFFFF);
    rd(OFS_STAT, 33'h243);
    rd(8'h24, 33'h100000000);
    // Power cycle drops register values
    rstn_i <= 1'b0;
    tick(2);
    rstn_i <= 1'b1;
    tick(2);
    rd(OFS_CTRL, 33'h0);
    rd(OFS_BANK_A, 33'h0);
    tick(3);
    report_and_stop();
  end
endmodule // pin_register_control_select_tb
